// ==== hw/chgsp_pkg.sv ====
// Purpose: Shared constants and types of the charger setpoint register logic.
// Assumes: 100 MHz system clock, SMBus write-word access only.
// Notes: Summary of operation below.
// Summary of operation
// R1: Voltage setpoint loads from SMBus write-word, command 0x15, 16-bit data.
// R2: Voltage code is bits 14..4, 16 mV per step; other bits ignored.
// R3: Voltage setpoint spans 1024 to 19200 mV; larger values clamp to 19200 mV.
// R4: Voltage code below 1024 mV stops charging.
// R5: Current setpoint loads from SMBus write-word, command 0x14, 16-bit data.
// R6: Current code is bits 12..7, 128 mA per step; other bits ignored.
// R7: Current setpoint spans 128 to 8064 mA; larger values clamp to 8064 mA.
// R8: Current setpoint of zero stops charging.
// R9: Reset clears both setpoints; charging waits for both commands again.
// R10: Both gate-drive outputs stay low while the charger is disabled.
// R11: Battery below 2.5 V forces 128 mA limit; stored setpoint kept.
// R12: Current loop governs below voltage setpoint, voltage loop at it.
// R13: Adapter current above input limit hands control to input loop.
// R14: Input limit loads via command 0x3F, 256 mA steps, resets to 256 mA.
// R15: No setpoint command within 175 s stops charging until both resent.
// R16: Battery-select change halts charging at once, resumes after 10 ms.
// R17: Enable needs both setpoints written, voltage not below minimum, current nonzero.
package chgsp_pkg;

  localparam longint unsigned CLK_HZ          = 100_000_000;
  localparam longint unsigned TIMEOUT_S       = 175;
  localparam longint unsigned TIMEOUT_CYCLES  = TIMEOUT_S * CLK_HZ;
  localparam longint unsigned SEL_HOLD_MS     = 10;
  localparam longint unsigned SEL_HOLD_CYCLES = (SEL_HOLD_MS * CLK_HZ) / 1000;

  localparam logic [6:0] SLAVE_ADDR = 7'h09;

  localparam logic [7:0] CMD_CHARGE_CURRENT = 8'h14;
  localparam logic [7:0] CMD_CHARGE_VOLTAGE = 8'h15;
  localparam logic [7:0] CMD_INPUT_LIMIT    = 8'h3f;

  localparam int VOLT_LSB_POS = 4;
  localparam int VOLT_MSB_POS = 14;
  localparam int CURR_LSB_POS = 7;
  localparam int CURR_MSB_POS = 12;
  localparam int INLIM_LSB_POS = 7;
  localparam int INLIM_MSB_POS = 12;

  localparam logic [14:0] VOLT_STEP_MV = 15'h0010;
  localparam logic [10:0] VOLT_MIN_CODE = 11'h040;
  localparam logic [14:0] VOLT_MAX_MV  = 15'h4b00;
  localparam logic [12:0] CURR_STEP_MA = 13'h0080;
  localparam logic [12:0] CURR_MAX_MA  = 13'h1f80;
  localparam logic [12:0] FOLDBACK_MA  = 13'h0080;
  localparam logic [13:0] INLIM_STEP_MA = 14'h0100;
  localparam logic [13:0] INLIM_MAX_MA  = 14'h2afc;

  localparam logic [10:0] VOLT_CODE_RESET  = 11'h000;
  localparam logic [5:0]  CURR_CODE_RESET  = 6'h00;
  localparam logic [5:0]  INLIM_CODE_RESET = 6'h01;

  typedef enum logic [1:0] {
    LOOP_OFF,
    LOOP_CHARGE_CURRENT,
    LOOP_VOLTAGE,
    LOOP_INPUT_CURRENT
  } chgsp_loop_t;

  typedef struct packed {
    logic [14:0] voltage_mv;
    logic [12:0] current_ma;
    logic [13:0] input_ma;
  } chgsp_setpoint_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic battery_select;
    logic battery_low;
    logic at_setpoint;
    logic input_over;
    logic pwm;
  } chgsp_inputs_t;

endpackage

// ==== hw/chgsp_sync.sv ====
// Purpose: Two-flop synchroniser for a group of asynchronous inputs.
// Assumes: Each bit is an independent level.
// Notes: Reset value chosen per bit so idle bus lines start high.
`timescale 1ns/100ps
`default_nettype none
module chgsp_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clock, // System clock.
  input  wire logic             rst,   // Synchronous reset, active high.
  input  wire logic [WIDTH-1:0] d,     // Asynchronous inputs.
  output logic      [WIDTH-1:0] q      // Synchronised outputs.
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clock) begin
    if (rst) begin
      meta_reg <= RESET_VAL;
      q        <= RESET_VAL;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule
`default_nettype wire

// ==== hw/chgsp_top.sv ====
// Purpose: SMBus setpoint registers and charge enable control of a battery charger.
// Assumes: Analog loops report as digital comparator levels; all such inputs are asynchronous.
// Notes: Registers are write-only; a read address phase is not acknowledged.
`timescale 1ns/100ps
`default_nettype none
module chgsp_top #(
  parameter logic [35:0] TIMEOUT_CYCLES  = 36'(chgsp_pkg::TIMEOUT_CYCLES),
  parameter logic [19:0] SEL_HOLD_CYCLES = 20'(chgsp_pkg::SEL_HOLD_CYCLES)
) (
  input  wire logic              clock,               // System clock, 100 MHz.
  input  wire logic              rst,                 // Synchronous reset, active high.
  input  wire logic              scl_in,              // SMBus clock pin.
  input  wire logic              sda_in,              // SMBus data pin, level seen on the wire.
  output logic                   sda_out,             // SMBus data drive value, always low.
  output logic                   sda_oe,              // High while pulling SDA low.
  input  wire logic              battery_select_in,   // Low picks first battery, high the second.
  input  wire logic              battery_low_in,      // Battery voltage below 2.5 V.
  input  wire logic              at_setpoint_in,      // Selected battery reached voltage setpoint.
  input  wire logic              input_over_in,       // Adapter current above input limit.
  input  wire logic              pwm_in,              // Modulator phase, high selects high-side.
  output logic                   high_side_gate_out,  // High-side gate drive.
  output logic                   low_side_gate_out,   // Low-side gate drive.
  output logic                   charge_enable,       // Charger running.
  output logic                   remote_sense_second, // High when second battery sense is monitored.
  output chgsp_pkg::chgsp_loop_t loop_select,         // Regulation loop in control.
  output chgsp_pkg::chgsp_setpoint_t setpoint         // Effective setpoints in mV and mA.
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_DATA_LOW,
    ST_DATA_HIGH,
    ST_IGNORE
  } chgsp_bus_state_t;

  chgsp_pkg::chgsp_inputs_t raw_in;
  chgsp_pkg::chgsp_inputs_t syn;

  assign raw_in = '{scl: scl_in, sda: sda_in, battery_select: battery_select_in,
                    battery_low: battery_low_in, at_setpoint: at_setpoint_in,
                    input_over: input_over_in, pwm: pwm_in};

  chgsp_sync #(
    .WIDTH     (7),
    .RESET_VAL (7'h60)
  ) u_sync (
    .clock (clock),
    .rst   (rst),
    .d     (raw_in),
    .q     (syn)
  );

  // SMBus receiver.
  chgsp_bus_state_t bus_state_reg;
  logic             scl_prev_reg;
  logic             sda_prev_reg;
  logic [7:0]       shift_reg;
  logic [3:0]       bit_cnt_reg;
  logic             ack_phase_reg;
  logic [7:0]       cmd_reg;
  logic [7:0]       data_low_reg;
  logic [15:0]      wr_data_reg;
  logic [7:0]       wr_cmd_reg;
  logic             wr_stb_reg;
  logic             scl_rise;
  logic             scl_fall;
  logic             bus_start;
  logic             bus_stop;

  assign scl_rise  = syn.scl & ~scl_prev_reg;
  assign scl_fall  = ~syn.scl & scl_prev_reg;
  assign bus_start = syn.scl & scl_prev_reg & sda_prev_reg & ~syn.sda;
  assign bus_stop  = syn.scl & scl_prev_reg & ~sda_prev_reg & syn.sda;

  always_ff @(posedge clock) begin
    if (rst) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= syn.scl;
      sda_prev_reg <= syn.sda;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      bus_state_reg <= ST_IDLE;
      shift_reg     <= 8'h00;
      bit_cnt_reg   <= 4'h0;
      ack_phase_reg <= 1'b0;
      sda_oe        <= 1'b0;
      cmd_reg       <= 8'h00;
      data_low_reg  <= 8'h00;
      wr_data_reg   <= 16'h0000;
      wr_cmd_reg    <= 8'h00;
      wr_stb_reg    <= 1'b0;
    end else begin
      wr_stb_reg <= 1'b0;
      if (bus_start) begin
        bus_state_reg <= ST_ADDR;
        bit_cnt_reg   <= 4'h0;
        ack_phase_reg <= 1'b0;
        sda_oe        <= 1'b0;
      end else if (bus_stop) begin
        bus_state_reg <= ST_IDLE;
        ack_phase_reg <= 1'b0;
        sda_oe        <= 1'b0;
      end else if (bus_state_reg != ST_IDLE) begin
        if (scl_rise && bit_cnt_reg < 4'h8) begin
          shift_reg   <= {shift_reg[6:0], syn.sda};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end else if (scl_fall && ack_phase_reg) begin
          // Acknowledge slot over; let the line go before the next bit.
          ack_phase_reg <= 1'b0;
          sda_oe        <= 1'b0;
          bit_cnt_reg   <= 4'h0;
        end else if (scl_fall && bit_cnt_reg == 4'h8) begin
          ack_phase_reg <= 1'b1;
          case (bus_state_reg)
            ST_ADDR: begin
              if (shift_reg[7:1] == chgsp_pkg::SLAVE_ADDR && !shift_reg[0]) begin
                sda_oe        <= 1'b1;
                bus_state_reg <= ST_CMD;
              end else begin
                bus_state_reg <= ST_IGNORE;
              end
            end
            ST_CMD: begin
              sda_oe        <= 1'b1;
              cmd_reg       <= shift_reg;
              bus_state_reg <= ST_DATA_LOW;
            end
            ST_DATA_LOW: begin
              sda_oe        <= 1'b1;
              data_low_reg  <= shift_reg;
              bus_state_reg <= ST_DATA_HIGH;
            end
            ST_DATA_HIGH: begin
              // Word complete: low byte first, then high byte.
              sda_oe        <= 1'b1;
              wr_data_reg   <= {shift_reg, data_low_reg}; // R1 R5
              wr_cmd_reg    <= cmd_reg;
              wr_stb_reg    <= 1'b1;
              bus_state_reg <= ST_IGNORE;
            end
            default: begin
              sda_oe <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // Setpoint storage and command watchdog.
  logic [10:0] volt_code_reg;
  logic [5:0]  curr_code_reg;
  logic [5:0]  inlim_code_reg;
  logic        volt_written_reg;
  logic        curr_written_reg;
  logic [35:0] wdog_cnt_reg;
  logic        wdog_expired;
  logic        wr_volt;
  logic        wr_curr;

  assign wr_volt      = wr_stb_reg && wr_cmd_reg == chgsp_pkg::CMD_CHARGE_VOLTAGE;
  assign wr_curr      = wr_stb_reg && wr_cmd_reg == chgsp_pkg::CMD_CHARGE_CURRENT;
  assign wdog_expired = volt_written_reg && curr_written_reg && wdog_cnt_reg >= TIMEOUT_CYCLES - 36'h1;

  always_ff @(posedge clock) begin
    if (rst) begin
      volt_code_reg    <= chgsp_pkg::VOLT_CODE_RESET; // R9
      curr_code_reg    <= chgsp_pkg::CURR_CODE_RESET; // R9
      inlim_code_reg   <= chgsp_pkg::INLIM_CODE_RESET; // R14
      volt_written_reg <= 1'b0;
      curr_written_reg <= 1'b0;
    end else begin
      // A timeout landing with a write keeps the write: the write is evaluated last.
      if (wdog_expired) begin
        volt_written_reg <= 1'b0; // R15
        curr_written_reg <= 1'b0; // R15
      end
      if (wr_volt) begin
        volt_code_reg    <= wr_data_reg[chgsp_pkg::VOLT_MSB_POS:chgsp_pkg::VOLT_LSB_POS]; // R2
        volt_written_reg <= 1'b1;
      end
      if (wr_curr) begin
        curr_code_reg    <= wr_data_reg[chgsp_pkg::CURR_MSB_POS:chgsp_pkg::CURR_LSB_POS]; // R6
        curr_written_reg <= 1'b1;
      end
      if (wr_stb_reg && wr_cmd_reg == chgsp_pkg::CMD_INPUT_LIMIT) begin
        inlim_code_reg <= wr_data_reg[chgsp_pkg::INLIM_MSB_POS:chgsp_pkg::INLIM_LSB_POS]; // R14
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wdog_cnt_reg <= 36'h0;
    end else if (wr_volt || wr_curr || !(volt_written_reg && curr_written_reg)) begin
      wdog_cnt_reg <= 36'h0; // R15
    end else begin
      wdog_cnt_reg <= wdog_cnt_reg + 36'h1;
    end
  end

  // Battery-select change hold-off.
  logic        sel_prev_reg;
  logic [19:0] hold_cnt_reg;
  logic        sel_change;

  assign sel_change = syn.battery_select ^ sel_prev_reg;

  always_ff @(posedge clock) begin
    if (rst) begin
      sel_prev_reg <= 1'b0;
      hold_cnt_reg <= 20'h0;
    end else begin
      sel_prev_reg <= syn.battery_select;
      if (sel_change) begin
        hold_cnt_reg <= SEL_HOLD_CYCLES; // R16
      end else if (hold_cnt_reg != 20'h0) begin
        hold_cnt_reg <= hold_cnt_reg - 20'h1;
      end
    end
  end

  // Effective setpoints and enable.
  logic [14:0] volt_mv;
  logic [12:0] curr_ma;
  logic [13:0] inlim_ma;
  logic        enable_next;

  always_comb begin
    volt_mv = 15'(volt_code_reg * chgsp_pkg::VOLT_STEP_MV);
    if (volt_mv > chgsp_pkg::VOLT_MAX_MV) begin
      volt_mv = chgsp_pkg::VOLT_MAX_MV; // R3
    end
    curr_ma = 13'(curr_code_reg * chgsp_pkg::CURR_STEP_MA);
    if (curr_ma > chgsp_pkg::CURR_MAX_MA) begin
      curr_ma = chgsp_pkg::CURR_MAX_MA; // R7
    end
    if (syn.battery_low) begin
      curr_ma = chgsp_pkg::FOLDBACK_MA; // R11
    end
    // An input-limit code of zero still gives the lowest step.
    inlim_ma = 14'(inlim_code_reg * chgsp_pkg::INLIM_STEP_MA);
    if (inlim_code_reg == 6'h00) begin
      inlim_ma = chgsp_pkg::INLIM_STEP_MA; // R14
    end else if (inlim_ma > chgsp_pkg::INLIM_MAX_MA) begin
      inlim_ma = chgsp_pkg::INLIM_MAX_MA;
    end
  end

  assign enable_next = volt_written_reg && curr_written_reg && !wdog_expired // R9 R17
                       && volt_code_reg >= chgsp_pkg::VOLT_MIN_CODE         // R4
                       && curr_code_reg != 6'h00                            // R8
                       && hold_cnt_reg == 20'h0 && !sel_change;             // R16

  always_ff @(posedge clock) begin
    if (rst) begin
      charge_enable       <= 1'b0;
      remote_sense_second <= 1'b0;
      setpoint            <= '0;
    end else begin
      charge_enable       <= enable_next;
      remote_sense_second <= syn.battery_select; // R12
      setpoint            <= '{voltage_mv: volt_mv, current_ma: curr_ma, input_ma: inlim_ma};
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      loop_select <= chgsp_pkg::LOOP_OFF;
    end else if (!enable_next) begin
      loop_select <= chgsp_pkg::LOOP_OFF;
    end else if (syn.input_over) begin
      loop_select <= chgsp_pkg::LOOP_INPUT_CURRENT; // R13
    end else if (syn.at_setpoint) begin
      loop_select <= chgsp_pkg::LOOP_VOLTAGE; // R12
    end else begin
      loop_select <= chgsp_pkg::LOOP_CHARGE_CURRENT; // R12
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      high_side_gate_out <= 1'b0;
      low_side_gate_out  <= 1'b0;
    end else begin
      high_side_gate_out <= enable_next & syn.pwm;  // R10
      low_side_gate_out  <= enable_next & ~syn.pwm; // R10
    end
  end

endmodule
`default_nettype wire

// ==== dv/chgsp_checker.sv ====
// Purpose: Port-level assertions for the charger setpoint register logic.
// Assumes: Sees only top-module ports; one clock domain.
// Notes: Bound into chgsp_top below the module.
`timescale 1ns/100ps
`default_nettype none
module chgsp_checker (
  input wire logic                       clock,               // System clock.
  input wire logic                       rst,                 // Synchronous reset.
  input wire logic                       sda_out,             // SDA drive value.
  input wire logic                       high_side_gate_out,  // High-side gate.
  input wire logic                       low_side_gate_out,   // Low-side gate.
  input wire logic                       charge_enable,       // Charger running.
  input wire logic                       remote_sense_second, // Sense select.
  input wire chgsp_pkg::chgsp_loop_t     loop_select,         // Loop in control.
  input wire chgsp_pkg::chgsp_setpoint_t setpoint             // Effective setpoints.
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_gates_off;
    !charge_enable |-> !high_side_gate_out && !low_side_gate_out;
  endproperty
  a_gates_off: assert property (p_gates_off) else $error("gate drive while charger off");
  property p_gate_excl;
    !(high_side_gate_out && low_side_gate_out);
  endproperty
  a_gate_excl: assert property (p_gate_excl) else $error("both gates high");
  property p_loop_off;
    !charge_enable |-> loop_select == chgsp_pkg::LOOP_OFF;
  endproperty
  a_loop_off: assert property (p_loop_off) else $error("loop active while off");
  property p_en_volt;
    charge_enable && $past(charge_enable) |-> setpoint.voltage_mv >= 15'h0400;
  endproperty
  a_en_volt: assert property (p_en_volt) else $error("enabled below minimum voltage");
  property p_volt_range;
    setpoint.voltage_mv <= 15'h4b00 && setpoint.voltage_mv[3:0] == 4'h0;
  endproperty
  a_volt_range: assert property (p_volt_range) else $error("voltage setpoint off grid");
  property p_curr_range;
    setpoint.current_ma <= 13'h1f80 && setpoint.current_ma[6:0] == 7'h00;
  endproperty
  a_curr_range: assert property (p_curr_range) else $error("current setpoint off grid");
  property p_inlim;
    !$past(rst) |-> setpoint.input_ma >= 14'h0100 && setpoint.input_ma <= 14'h2afc;
  endproperty
  a_inlim: assert property (p_inlim) else $error("input limit out of range");
  property p_sda_low;
    sda_out == 1'b0;
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("sda drive value high");
  property p_sel_halt;
    $changed(remote_sense_second) |-> ##2 !charge_enable [*8];
  endproperty
  a_sel_halt: assert property (p_sel_halt) else $error("charging during select hold");
  c_enable: cover property ($rose(charge_enable));
  c_input_loop: cover property (loop_select == chgsp_pkg::LOOP_INPUT_CURRENT);
  c_sel: cover property ($changed(remote_sense_second));
endmodule
bind chgsp_top chgsp_checker i_chk (.clock(clock), .rst(rst), .sda_out(sda_out),
  .high_side_gate_out(high_side_gate_out), .low_side_gate_out(low_side_gate_out),
  .charge_enable(charge_enable), .remote_sense_second(remote_sense_second),
  .loop_select(loop_select), .setpoint(setpoint));
`default_nettype wire

// ==== dv/chgsp_host.sv ====
// Purpose: SMBus host model issuing write-word frames.
// Assumes: Open-drain wire with pull-up resolved by the bench.
// Notes: Phases of 8 clocks keep the device's 4-clock minimum.
`timescale 1ns/100ps
`default_nettype none
module chgsp_host (
  input  wire logic clock,    // System clock.
  input  wire logic sda_wire, // Resolved SDA level.
  output logic      scl,      // SCL, high when released.
  output logic      sda_drv,  // SDA drive, high when released.
  output logic      acked     // Every byte of last frame acknowledged.
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    acked = 1'b1;
  end
  task automatic half();
    repeat (8) @(negedge clock);
  endtask
  // The ninth bit releases SDA so the device can acknowledge.
  task automatic put_byte(input logic [7:0] b);
    for (int i = 7; i >= -1; i--) begin
      sda_drv = (i < 0) ? 1'b1 : b[i];
      half();
      scl = 1'b1;
      half();
      if (i < 0 && sda_wire !== 1'b0) acked = 1'b0;
      scl = 1'b0;
    end
  endtask
  // The address byte is a parameter of the frame so refused addresses can be tried.
  task automatic write_word(input logic [7:0] addr, input logic [7:0] cmd, input logic [15:0] data);
    acked = 1'b1;
    sda_drv = 1'b0;
    half();
    scl = 1'b0;
    put_byte(addr);
    put_byte(cmd);
    put_byte(data[7:0]);
    put_byte(data[15:8]);
    sda_drv = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_drv = 1'b1;
    half();
  endtask
endmodule
`default_nettype wire

// ==== dv/tb_chgsp_top.sv ====
// Purpose: Self-checking bench for the charger setpoint register logic.
// Assumes: Short timeout and select hold parameters.
// Notes: Expectations come from the bench functions, task expressions and literal constants.
`timescale 1ns/100ps
`default_nettype none
module tb_chgsp_top;
  localparam int SEL_HOLD = 50;
  localparam int TMO = 4000;
  logic clock, rst, scl, sda_drv, acked, sda_out, sda_oe, sda_wire;
  logic bsel, blow, atsp, iover, pwm, hi, lo, en, rs2;
  chgsp_pkg::chgsp_loop_t loop;
  chgsp_pkg::chgsp_setpoint_t sp;
  int error_cnt, check_count;
  logic [15:0] v, c;
  logic [15:0] cv [5] = '{16'hffff, 16'h03f0, 16'h0400, 16'h8400, 16'h040f};
  logic [15:0] cc [5] = '{16'hffff, 16'h0400, 16'h0000, 16'he080, 16'h007f};
  assign sda_wire = sda_drv & ~sda_oe;
  chgsp_host i_host (.clock(clock), .sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv), .acked(acked));
  chgsp_top #(.TIMEOUT_CYCLES(36'(TMO)), .SEL_HOLD_CYCLES(20'(SEL_HOLD))) i_dut (
    .clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
    .battery_select_in(bsel), .battery_low_in(blow), .at_setpoint_in(atsp), .input_over_in(iover),
    .pwm_in(pwm), .high_side_gate_out(hi), .low_side_gate_out(lo), .charge_enable(en),
    .remote_sense_second(rs2), .loop_select(loop), .setpoint(sp));
  function automatic logic [15:0] mv_of(input logic [15:0] d);
    return ({1'b0, d[14:4], 4'h0} > 16'h4b00) ? 16'h4b00 : {1'b0, d[14:4], 4'h0};
  endfunction
  function automatic logic [15:0] lim_of(input logic [15:0] d);
    if (d[12:7] == 6'h00) return 16'h0100;
    return ({2'h0, d[12:7], 8'h00} > 16'h2afc) ? 16'h2afc : {2'h0, d[12:7], 8'h00};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic settle();
    repeat (6) @(negedge clock);
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
    i_host.write_word({chgsp_pkg::SLAVE_ADDR, 1'b0}, cmd, d);
    settle();
    chk(16'(acked), 16'h0001);
  endtask
  task automatic pair(input logic [15:0] vd, input logic [15:0] cd);
    wr(8'h15, vd);
    wr(8'h14, cd);
    chk(16'(en), 16'((vd[14:4] >= 11'h040) && (cd[12:7] != 6'h00)));
    if (vd[14:4] >= 11'h040) chk(16'(sp.voltage_mv), mv_of(vd));
    chk(16'(sp.current_ma), {3'h0, cd[12:7], 7'h00});
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    repeat (60000) @(posedge clock);
    error_cnt++;
    conclude();
  end
  initial begin
    {rst, bsel, blow, atsp, iover, pwm} = 6'h20;
    error_cnt = 0;
    check_count = 0;
    void'($urandom(32'hecbb));
    repeat (6) @(negedge clock);
    rst = 1'b0;
    settle();
    chk(16'({en, hi, lo}), 16'h0000);
    chk(16'(sp.input_ma), 16'h0100);
    wr(8'h3f, 16'h0000);
    chk(16'(sp.input_ma), 16'h0100);
    wr(8'h3f, 16'h1f80);
    chk(16'(sp.input_ma), 16'h2afc);
    v = 16'($urandom);
    wr(8'h3f, v);
    chk(16'(sp.input_ma), lim_of(v));
    $display("test reset and input limit done");
    wr(8'h15, 16'h41a0);
    chk(16'(en), 16'h0000);
    wr(8'h20, 16'h1234);
    chk(16'(en), 16'h0000);
    pair(16'h41a0, 16'h0400);
    for (int i = 0; i < 5; i++) pair(cv[i], cc[i]);
    for (int i = 0; i < 6; i++) pair(16'($urandom), 16'($urandom));
    pair(16'h41a0, 16'h0c80);
    $display("test setpoints done");
    blow = 1'b1;
    settle();
    chk(16'(sp.current_ma), 16'h0080);
    blow = 1'b0;
    settle();
    chk(16'(sp.current_ma), 16'h0c80);
    {iover, atsp, pwm} = 3'h7;
    settle();
    chk(16'(loop), 16'(chgsp_pkg::LOOP_INPUT_CURRENT));
    chk(16'({hi, lo}), 16'h0002);
    {iover, pwm} = 2'h0;
    settle();
    chk(16'(loop), 16'(chgsp_pkg::LOOP_VOLTAGE));
    chk(16'({hi, lo}), 16'h0001);
    atsp = 1'b0;
    settle();
    chk(16'(loop), 16'(chgsp_pkg::LOOP_CHARGE_CURRENT));
    $display("test foldback and loops done");
    bsel = 1'b1;
    settle();
    chk(16'({en, hi, lo, rs2}), 16'h0001);
    repeat (SEL_HOLD - 8) @(negedge clock);
    chk(16'(en), 16'h0000);
    repeat (16) @(negedge clock);
    chk(16'(en), 16'h0001);
    $display("test battery select done");
    repeat (TMO + 20) @(negedge clock);
    chk(16'(en), 16'h0000);
    wr(8'h15, 16'h41a0);
    chk(16'(en), 16'h0000);
    wr(8'h14, 16'h0c80);
    chk(16'(en), 16'h0001);
    $display("test timeout done");
    i_host.write_word({chgsp_pkg::SLAVE_ADDR ^ 7'h01, 1'b0}, 8'h14, 16'h0000);
    settle();
    chk(16'({acked, en}), 16'h0001);
    i_host.write_word({chgsp_pkg::SLAVE_ADDR, 1'b1}, 8'h14, 16'h0000);
    settle();
    chk(16'({acked, en}), 16'h0001);
    $display("test refused address and read done");
    conclude();
  end
endmodule
`default_nettype wire
